// >>> acem_matcher.sv
/*
  IPv4 access rule entry matcher: one entry, compared against the parsed
  IPv4 header of each frame; the result is registered one cycle later.
  Assumes the frame parser presents all fields together with hdr_valid
  and that sub-criteria results for ICMP, UDP and TCP come from outside.
*/
`timescale 1ns/1ps
module acem_matcher (
  input wire logic mclk, // 125 MHz core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [3:0] reg_addr, // Register word address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic hdr_valid, // Parsed header present
  input wire logic [3:0] frame_type, // Frame type class from parser
  input wire logic [7:0] ip_proto, // IPv4 protocol field
  input wire logic [7:0] ip_ttl, // Time-to-live field
  input wire logic ip_more_frag, // More-fragments bit
  input wire logic [12:0] ip_frag_offset, // Fragment offset field
  input wire logic ip_options, // Options flag
  input wire logic [31:0] source_ip_addr, // Source address
  input wire logic [31:0] destination_ip_addr, // Destination address
  input wire logic icmp_sub_ok, // ICMP sub-criteria satisfied
  input wire logic udp_sub_ok, // UDP port sub-criteria satisfied
  input wire logic tcp_sub_ok, // TCP port and flag sub-criteria satisfied
  output logic hit_valid, // Result strobe, one cycle
  output logic hit // Frame hits the entry
);
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [7:0] proto_ff, nxt_proto;
  logic [31:0] src_addr_ff, nxt_src_addr;
  logic [31:0] src_mask_ff, nxt_src_mask;
  logic [31:0] dst_addr_ff, nxt_dst_addr;
  logic [31:0] dst_mask_ff, nxt_dst_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] hits_ff, nxt_hits;
  logic last_hit_ff, nxt_last_hit;
  logic valid_ff, nxt_valid;
  logic hit_ff, nxt_hit;

  logic [3:0] cfg_ftype;
  acem_pkg::acem_psel_t cfg_psel;
  acem_pkg::acem_tri_t cfg_ttl, cfg_frag, cfg_opt;
  acem_pkg::acem_adr_t cfg_src, cfg_dst;
  logic ipv4_sel, proto_ok, ttl_ok, frag_ok, opt_ok, src_ok, dst_ok;
  logic is_frag, ipv4_ok, type_ok, match;

  assign cfg_ftype = ctrl_ff[acem_pkg::CTRL_FTYPE_LSB +: 4];
  assign cfg_psel = acem_pkg::acem_psel_t'(ctrl_ff[acem_pkg::CTRL_PSEL_LSB +: 3]);
  assign cfg_ttl = acem_pkg::acem_tri_t'(ctrl_ff[acem_pkg::CTRL_TTL_LSB +: 2]);
  assign cfg_frag = acem_pkg::acem_tri_t'(ctrl_ff[acem_pkg::CTRL_FRAG_LSB +: 2]);
  assign cfg_opt = acem_pkg::acem_tri_t'(ctrl_ff[acem_pkg::CTRL_OPT_LSB +: 2]);
  assign cfg_src = acem_pkg::acem_adr_t'(ctrl_ff[acem_pkg::CTRL_SRC_LSB +: 2]);
  assign cfg_dst = acem_pkg::acem_adr_t'(ctrl_ff[acem_pkg::CTRL_DST_LSB +: 2]);

  function automatic logic tri_ok(input acem_pkg::acem_tri_t sel, input logic flag);
    case (sel)
      acem_pkg::TRI_NO: tri_ok = ~flag;
      acem_pkg::TRI_YES: tri_ok = flag;
      default: tri_ok = 1'b1;
    endcase
  endfunction

  function automatic logic adr_ok(input acem_pkg::acem_adr_t sel, input logic [31:0] a,
                                  input logic [31:0] cfg, input logic [31:0] mask);
    case (sel)
      acem_pkg::ADR_HOST: adr_ok = (a == cfg);
      acem_pkg::ADR_NET: adr_ok = ((a & mask) == (cfg & mask));
      default: adr_ok = 1'b1;
    endcase
  endfunction

  // Criteria evaluation
  always_comb begin
    case (cfg_psel)
      acem_pkg::PSEL_VALUE: proto_ok = (ip_proto == proto_ff);
      acem_pkg::PSEL_ICMP: proto_ok = (ip_proto == acem_pkg::PROTO_ICMP) & icmp_sub_ok;
      acem_pkg::PSEL_UDP: proto_ok = (ip_proto == acem_pkg::PROTO_UDP) & udp_sub_ok;
      acem_pkg::PSEL_TCP: proto_ok = (ip_proto == acem_pkg::PROTO_TCP) & tcp_sub_ok;
      default: proto_ok = 1'b1;
    endcase
  end

  assign ttl_ok = tri_ok(cfg_ttl == acem_pkg::TRI_NO ? acem_pkg::TRI_YES :
                         cfg_ttl == acem_pkg::TRI_YES ? acem_pkg::TRI_NO : acem_pkg::TRI_ANY,
                         ip_ttl == 8'h00);
  assign is_frag = ip_more_frag | (ip_frag_offset != 13'h0000);
  assign frag_ok = tri_ok(cfg_frag, is_frag);
  assign opt_ok = tri_ok(cfg_opt, ip_options);
  assign src_ok = adr_ok(cfg_src, source_ip_addr, src_addr_ff, src_mask_ff);
  assign dst_ok = adr_ok(cfg_dst, destination_ip_addr, dst_addr_ff, dst_mask_ff);
  assign ipv4_sel = (cfg_ftype == acem_pkg::FTYPE_IPV4);
  assign ipv4_ok = ~ipv4_sel | (proto_ok & ttl_ok & frag_ok & opt_ok & src_ok & dst_ok);
  assign type_ok = (cfg_ftype == acem_pkg::FTYPE_ANY) | (frame_type == cfg_ftype);
  assign match = type_ok & ipv4_ok;

  // Register writes, read data and result staging
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_proto = proto_ff;
    nxt_src_addr = src_addr_ff;
    nxt_src_mask = src_mask_ff;
    nxt_dst_addr = dst_addr_ff;
    nxt_dst_mask = dst_mask_ff;
    nxt_rdata = rdata_ff;
    nxt_valid = hdr_valid;
    nxt_hit = hdr_valid & match;
    nxt_hits = hits_ff;
    nxt_last_hit = last_hit_ff;
    if (hdr_valid) begin
      nxt_last_hit = match;
      if (match) begin
        nxt_hits = hits_ff + 32'h0000_0001;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        acem_pkg::REG_CTRL: nxt_ctrl = reg_wdata;
        acem_pkg::REG_PROTO: nxt_proto = reg_wdata[7:0];
        acem_pkg::REG_SRC_ADDR: nxt_src_addr = reg_wdata;
        acem_pkg::REG_SRC_MASK: nxt_src_mask = reg_wdata;
        acem_pkg::REG_DST_ADDR: nxt_dst_addr = reg_wdata;
        acem_pkg::REG_DST_MASK: nxt_dst_mask = reg_wdata;
        // A clear in the same cycle as a hit wins; that hit is not counted
        acem_pkg::REG_HITS: nxt_hits = acem_pkg::WORD_RST;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        acem_pkg::REG_CTRL: nxt_rdata = {14'h0000, ctrl_ff[17:0]};
        acem_pkg::REG_PROTO: nxt_rdata = {24'h00_0000, proto_ff};
        acem_pkg::REG_SRC_ADDR: nxt_rdata = src_addr_ff;
        acem_pkg::REG_SRC_MASK: nxt_rdata = src_mask_ff;
        acem_pkg::REG_DST_ADDR: nxt_rdata = dst_addr_ff;
        acem_pkg::REG_DST_MASK: nxt_rdata = dst_mask_ff;
        acem_pkg::REG_STATUS: nxt_rdata = {31'h0000_0000, last_hit_ff};
        acem_pkg::REG_HITS: nxt_rdata = hits_ff;
        default: nxt_rdata = acem_pkg::UNMAPPED_RD;
      endcase
    end else begin
      nxt_rdata = acem_pkg::UNMAPPED_RD;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= acem_pkg::CTRL_RST;
      proto_ff <= 8'h00;
      src_addr_ff <= acem_pkg::WORD_RST;
      src_mask_ff <= acem_pkg::WORD_RST;
      dst_addr_ff <= acem_pkg::WORD_RST;
      dst_mask_ff <= acem_pkg::WORD_RST;
      rdata_ff <= acem_pkg::WORD_RST;
      hits_ff <= acem_pkg::WORD_RST;
      last_hit_ff <= 1'b0;
      valid_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      proto_ff <= nxt_proto;
      src_addr_ff <= nxt_src_addr;
      src_mask_ff <= nxt_src_mask;
      dst_addr_ff <= nxt_dst_addr;
      dst_mask_ff <= nxt_dst_mask;
      rdata_ff <= nxt_rdata;
      hits_ff <= nxt_hits;
      last_hit_ff <= nxt_last_hit;
      valid_ff <= nxt_valid;
      hit_ff <= nxt_hit;
    end
  end

  assign reg_rdata = rdata_ff;
  assign hit_valid = valid_ff;
  assign hit = hit_ff;

  // Checks
  sequence hdr_s;
    hdr_valid;
  endsequence

  sequence result_s;
    hit_valid;
  endsequence

  hit_needs_hdr_a: assert property (@(posedge mclk) disable iff (rst)
    hit |-> $past(hdr_valid) && $past(match))
    else $error("hit without matching header");
  result_timing_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_s |=> result_s)
    else $error("result not one cycle after header");
  non_ipv4_free_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && !ipv4_sel && type_ok |=> hit)
    else $error("IPv4 criteria used without IPv4 type");
  proto_value_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_psel == acem_pkg::PSEL_VALUE && ip_proto != proto_ff |=> !hit)
    else $error("specific protocol mismatch hit");
  proto_any_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_psel == acem_pkg::PSEL_ANY |-> proto_ok)
    else $error("protocol any did not pass");
  icmp_sel_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_psel == acem_pkg::PSEL_ICMP
    && (ip_proto != acem_pkg::PROTO_ICMP || !icmp_sub_ok) |=> !hit)
    else $error("ICMP selection hit wrongly");
  udp_sel_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_psel == acem_pkg::PSEL_UDP
    && (ip_proto != acem_pkg::PROTO_UDP || !udp_sub_ok) |=> !hit)
    else $error("UDP selection hit wrongly");
  tcp_sel_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_psel == acem_pkg::PSEL_TCP
    && (ip_proto != acem_pkg::PROTO_TCP || !tcp_sub_ok) |=> !hit)
    else $error("TCP selection hit wrongly");
  ttl_zero_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && (cfg_ttl == acem_pkg::TRI_NO && ip_ttl != 8'h00
    || cfg_ttl == acem_pkg::TRI_YES && ip_ttl == 8'h00) |=> !hit)
    else $error("time-to-live criterion violated");
  frag_rule_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_frag == acem_pkg::TRI_NO
    && (ip_more_frag || ip_frag_offset != 13'h0000) |=> !hit)
    else $error("fragment excluded but hit");
  opt_rule_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_opt == acem_pkg::TRI_YES && !ip_options |=> !hit)
    else $error("options required but hit");
  src_host_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_src == acem_pkg::ADR_HOST
    && source_ip_addr != src_addr_ff |=> !hit)
    else $error("source host mismatch hit");
  dst_net_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_dst == acem_pkg::ADR_NET
    && ((destination_ip_addr ^ dst_addr_ff) & dst_mask_ff) != 32'h0000_0000 |=> !hit)
    else $error("destination network mismatch hit");

  // Result strobe, all don't-care hit and criteria exclusions written from the inputs
  valid_drop_a: assert property (@(posedge mclk) disable iff (rst)
    !hdr_valid |=> !hit_valid)
    else $error("result strobe without header");
  hit_in_valid_a: assert property (@(posedge mclk) disable iff (rst)
    hit |-> hit_valid)
    else $error("hit outside result strobe");
  ftype_miss_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && cfg_ftype != acem_pkg::FTYPE_ANY
    && frame_type != cfg_ftype |=> !hit)
    else $error("frame type mismatch hit");
  all_any_hit_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ctrl_ff[17:0] == 18'h00000 |=> hit)
    else $error("all don't-care entry missed");
  frag_yes_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_frag == acem_pkg::TRI_YES
    && !ip_more_frag && ip_frag_offset == 13'h0000 |=> !hit)
    else $error("fragment required but hit");
  opt_no_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_opt == acem_pkg::TRI_NO && ip_options |=> !hit)
    else $error("options excluded but hit");
  src_net_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_src == acem_pkg::ADR_NET
    && ((source_ip_addr ^ src_addr_ff) & src_mask_ff) != 32'h0000_0000 |=> !hit)
    else $error("source network mismatch hit");
  dst_host_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && ipv4_sel && cfg_dst == acem_pkg::ADR_HOST
    && destination_ip_addr != dst_addr_ff |=> !hit)
    else $error("destination host mismatch hit");

  // Register port and hit counter
  sequence proto_wr_s;
    reg_wr && reg_addr == acem_pkg::REG_PROTO;
  endsequence

  proto_write_a: assert property (@(posedge mclk) disable iff (rst)
    proto_wr_s |=> proto_ff == $past(reg_wdata[7:0]))
    else $error("protocol value write lost");
  ctrl_write_a: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == acem_pkg::REG_CTRL |=> ctrl_ff == $past(reg_wdata))
    else $error("control write lost");
  hits_count_a: assert property (@(posedge mclk) disable iff (rst)
    hdr_valid && match && !(reg_wr && reg_addr == acem_pkg::REG_HITS)
    |=> hits_ff == $past(hits_ff) + 32'h0000_0001)
    else $error("hit not counted");
  hits_clear_a: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == acem_pkg::REG_HITS |=> hits_ff == acem_pkg::WORD_RST)
    else $error("hit counter not cleared");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd |=> reg_rdata == acem_pkg::UNMAPPED_RD)
    else $error("read data without read strobe");
  status_read_a: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == acem_pkg::REG_STATUS |=> reg_rdata == {31'h0, $past(last_hit_ff)})
    else $error("status read wrong");
endmodule // acem_matcher

// >>> acem_parser_model.sv
/*
  Frame parser stand-in: presents one parsed header per go pulse.
  Assumes the bench packs fields in the matcher's port order.
*/
`timescale 1ns/1ps
module acem_parser_model (
  input wire logic mclk, // Core clock
  input wire logic rst, // Reset, active high
  input wire logic go, // Send one header next cycle
  input wire logic [101:0] frame, // Packed header fields
  output logic hdr_valid, // Header strobe
  output logic [101:0] hdr // Fields, scrambled while idle
);
  logic vld_ff;
  logic [101:0] hdr_ff;
  logic [101:0] nxt_hdr;
  // Idle fields flip every cycle so stale values never look valid
  always_comb begin
    nxt_hdr = go ? frame : ~hdr_ff;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vld_ff <= 1'b0;
      hdr_ff <= '0;
    end else begin
      vld_ff <= go;
      hdr_ff <= nxt_hdr;
    end
  end
  assign hdr_valid = vld_ff;
  assign hdr = hdr_ff;
endmodule // acem_parser_model

// >>> acem_pkg.sv
/*
  Package for the IPv4 access rule entry matcher: register map, field
  layouts, reset values and selection encodings.
  Assumes a plain register port with read data one cycle after the strobe.
*/
package acem_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PROTO = 4'h1;
  localparam logic [3:0] REG_SRC_ADDR = 4'h2;
  localparam logic [3:0] REG_SRC_MASK = 4'h3;
  localparam logic [3:0] REG_DST_ADDR = 4'h4;
  localparam logic [3:0] REG_DST_MASK = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_HITS = 4'h7;
  // Control register field positions
  localparam int unsigned CTRL_FTYPE_LSB = 0;
  localparam int unsigned CTRL_PSEL_LSB = 4;
  localparam int unsigned CTRL_TTL_LSB = 8;
  localparam int unsigned CTRL_FRAG_LSB = 10;
  localparam int unsigned CTRL_OPT_LSB = 12;
  localparam int unsigned CTRL_SRC_LSB = 14;
  localparam int unsigned CTRL_DST_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  localparam logic [3:0] FTYPE_ANY = 4'h0;
  localparam logic [3:0] FTYPE_IPV4 = 4'h2;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  typedef enum logic [2:0] {
    PSEL_ANY = 3'h0, PSEL_VALUE = 3'h1, PSEL_ICMP = 3'h2, PSEL_UDP = 3'h3, PSEL_TCP = 3'h4
  } acem_psel_t;
  // Three-way criterion: don't-care, require clear, require set
  typedef enum logic [1:0] {
    TRI_ANY = 2'h0, TRI_NO = 2'h1, TRI_YES = 2'h2
  } acem_tri_t;
  typedef enum logic [1:0] {
    ADR_ANY = 2'h0, ADR_HOST = 2'h1, ADR_NET = 2'h2
  } acem_adr_t;
endpackage

// >>> tb_ipv4_access_entry_matcher.sv
/*
  Self-checking bench for the access rule entry matcher.
  Assumes the parser stand-in and the register map of acem_pkg.
*/
`timescale 1ns/1ps
module tb_ipv4_access_entry_matcher;
  localparam logic [3:0] V4 = acem_pkg::FTYPE_IPV4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [31:0] reg_rdata;
  logic hdr_valid, hit_valid, hit;
  logic [3:0] f_ft;
  logic [7:0] f_pr, f_ttl;
  logic f_mf, f_opt;
  logic [12:0] f_off;
  logic [31:0] f_sip, f_dip;
  logic [2:0] f_sub;
  logic [101:0] hdr;
  int n_errors = 0;
  int comparisons = 0;
  int nhit = 0;
  always #4 mclk = ~mclk;
  acem_parser_model parser (.mclk(mclk), .rst(rst), .go(go), .hdr_valid(hdr_valid), .hdr(hdr),
    .frame({f_ft, f_pr, f_ttl, f_mf, f_off, f_opt, f_sip, f_dip, f_sub}));
  acem_matcher dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hdr_valid(hdr_valid),
    .frame_type(hdr[101:98]), .ip_proto(hdr[97:90]), .ip_ttl(hdr[89:82]),
    .ip_more_frag(hdr[81]), .ip_frag_offset(hdr[80:68]), .ip_options(hdr[67]),
    .source_ip_addr(hdr[66:35]), .destination_ip_addr(hdr[34:3]), .icmp_sub_ok(hdr[2]),
    .udp_sub_ok(hdr[1]), .tcp_sub_ok(hdr[0]), .hit_valid(hit_valid), .hit(hit));
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] ft, input logic [2:0] ps,
      input logic [1:0] tt, fr, op, sa, da);
    ctl = {14'h0, da, sa, op, fr, tt, 1'b0, ps, ft};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", exp, reg_rdata);
    @(posedge mclk);
    #1 cmp("reg_rdata idle", 32'h0, reg_rdata);
  endtask
  task automatic dflt();
    f_ft = V4; f_pr = 8'h06; f_ttl = 8'h40; f_mf = 1'b0; f_off = 13'h0; f_opt = 1'b0;
    f_sip = 32'h0a00_0001; f_dip = 32'hc0a8_0101; f_sub = 3'b111;
  endtask
  // Send the current fields and judge the registered result
  task automatic chk(input logic exp);
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1 cmp("hit_valid", 32'h1, {31'h0, hit_valid});
    cmp("hit", {31'h0, exp}, {31'h0, hit});
    if (exp) nhit++;
    @(posedge mclk);
    #1 cmp("hit_valid low", 32'h0, {31'h0, hit_valid});
    cmp("hit low", 32'h0, {31'h0, hit});
    dflt();
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) rd(i[3:0], 32'h0);
    rd(4'hb, acem_pkg::UNMAPPED_RD);
    wr(acem_pkg::REG_SRC_ADDR, 32'h1234_5678);
    rd(acem_pkg::REG_SRC_ADDR, 32'h1234_5678);
    wr(acem_pkg::REG_STATUS, 32'h0000_0001);
    rd(acem_pkg::REG_STATUS, 32'h0);
    chk(1'b1);
    rd(acem_pkg::REG_STATUS, 32'h1);
  endtask
  task automatic t_ftype();
    wr(acem_pkg::REG_PROTO, 32'h0000_0099);
    wr(acem_pkg::REG_CTRL, ctl(4'h0, 3'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1));
    chk(1'b1);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    chk(1'b0);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    chk(1'b1);
    f_ft = 4'h1; chk(1'b0);
  endtask
  task automatic t_proto();
    f_pr = 8'h5a; chk(1'b1);
    wr(acem_pkg::REG_PROTO, 32'h0000_00ff);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    f_pr = 8'hff; chk(1'b1);
    f_pr = 8'hfe; chk(1'b0);
    wr(acem_pkg::REG_PROTO, 32'h0);
    f_pr = 8'h00; chk(1'b1);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    f_pr = 8'h01; f_sub = 3'b100; chk(1'b1);
    f_pr = 8'h01; f_sub = 3'b011; chk(1'b0);
    f_pr = 8'h11; chk(1'b0);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    f_pr = 8'h11; f_sub = 3'b010; chk(1'b1);
    f_pr = 8'h11; f_sub = 3'b101; chk(1'b0);
    chk(1'b0);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h4, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0));
    f_sub = 3'b001; chk(1'b1);
    f_sub = 3'b110; chk(1'b0);
    f_pr = 8'h11; chk(1'b0);
  endtask
  task automatic t_tri();
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0));
    f_ttl = 8'h00; chk(1'b1);
    f_ttl = 8'h01; chk(1'b0);
    f_ttl = 8'h00; f_mf = 1'b1; chk(1'b0);
    f_ttl = 8'h00; f_off = 13'h1fff; chk(1'b0);
    f_ttl = 8'h00; f_opt = 1'b1; chk(1'b0);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0));
    f_mf = 1'b1; f_opt = 1'b1; chk(1'b1);
    f_ttl = 8'h00; f_mf = 1'b1; f_opt = 1'b1; chk(1'b0);
    f_off = 13'h0001; f_opt = 1'b1; chk(1'b1);
    f_opt = 1'b1; chk(1'b0);
    f_mf = 1'b1; chk(1'b0);
  endtask
  task automatic t_addr();
    wr(acem_pkg::REG_SRC_ADDR, 32'h0a00_0001);
    wr(acem_pkg::REG_SRC_MASK, 32'hffff_ff00);
    wr(acem_pkg::REG_DST_ADDR, 32'hc0a8_0101);
    wr(acem_pkg::REG_DST_MASK, 32'hffff_f000);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1));
    chk(1'b1);
    f_sip = 32'h0a00_0003; chk(1'b0);
    f_dip = 32'hc0a8_0100; chk(1'b0);
    wr(acem_pkg::REG_CTRL, ctl(V4, 3'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2));
    f_sip = 32'h0a00_00fe; f_dip = 32'hc0a8_0fff; chk(1'b1);
    f_sip = 32'h0a00_0101; chk(1'b0);
    f_dip = 32'hc0a8_1101; chk(1'b0);
    rd(acem_pkg::REG_STATUS, 32'h0);
    rd(acem_pkg::REG_HITS, nhit);
    wr(acem_pkg::REG_HITS, 32'h0);
    rd(acem_pkg::REG_HITS, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    dflt();
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_ftype();
    t_proto();
    t_tri();
    t_addr();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule // tb_ipv4_access_entry_matcher
